// ===== logic/gpio_wake_port.sv
// GPIO port with set/clear/toggle, pull control and event wake logic
// Summary of operation
// - Bus wake enable lets bus events wake
// - Three-bit mode picks edge or level trigger
// - Bus autoclear enable resets to one
// - Pin autoclear enable resets to one
// - Writing bit eight clears bus flag
// - Writing bit n clears pin flag n
// - Eight pins form one port
// - Pull-ups on all pins except pin two
// - Enabled input paths show pin level
// - Output pins carry output value bits
// - Set register forces selected bits high
// - Clear register forces selected bits low
// - Toggle register inverts selected bits
// - Pin driven only while drive enabled
// - Each pin event has mode and enable
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module gpio_wake_port #(
	parameter int PINS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Pins
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe_n,
	output logic [PINS-1:0] pull_en,
	input wire logic bus_activity,
	// Wake and interrupt
	output logic wake_req,
	output logic irq
);
	import gpio_wake_pkg::*;
	if (PINS != 8) begin
		$error("Port logic serves exactly eight pins");
	end
	// ****************************
	// Helpers
	// ****************************
	function automatic logic [15:0] lane_mask(input logic [3:0] s);
		return {{8{s[1]}}, {8{s[0]}}};
	endfunction
	// Codes 5..7 alias 1..3
	function automatic logic trig(input logic [2:0] m, input logic cur, input logic prv);
		logic [2:0] e;
		e = (m > MODE_LOW) ? (m - 3'h4) : m;
		case (e)
			MODE_RISE: return cur & ~prv;
			MODE_FALL: return ~cur & prv;
			MODE_BOTH: return cur ^ prv;
			MODE_HIGH: return cur;
			MODE_LOW: return ~cur;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************
	// Register bus slave
	// ****************************
	logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [11:0] waddr_ff;
	logic [15:0] wdat_ff, wmask;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic wr_go, wr_hit;
	// Address and data may arrive in either order
	assign awready = ~aw_hold_ff & ~bvalid_ff;
	assign wready = ~w_hold_ff & ~bvalid_ff;
	assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign wmask = lane_mask(wstrb);
	assign arready = ~rvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	function automatic logic known(input logic [11:0] a);
		case (a)
			OFS_OUTPUT_DRIVE_EN, OFS_PULL_ENABLE, OFS_INPUT_PATH_EN, OFS_INPUT_LEVEL,
			OFS_OUTPUT_VALUE, OFS_OUTPUT_SET, OFS_OUTPUT_CLEAR, OFS_OUTPUT_TOGGLE,
			OFS_BUS_WAKE_CONFIG, OFS_EVENT_FLAG_CLEAR, OFS_PIN_EVENT_CFG_LO,
			OFS_PIN_EVENT_CFG_HI, OFS_EVENT_STATUS, OFS_EVENT_IRQ_EN: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	assign wr_hit = known(waddr_ff);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			waddr_ff <= 12'h000;
			wdat_ff <= 16'h0000;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold_ff <= 1'b1;
				waddr_ff <= {awaddr[11:2], 2'h0};
			end
			if (wvalid && wready) begin
				w_hold_ff <= 1'b1;
				wdat_ff <= wdata[15:0] & wmask;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	function automatic logic wr_at(input logic [11:0] a, input logic go, input logic [11:0] w);
		return go && (w == a);
	endfunction

	// ****************************
	// Configuration registers
	// ****************************
	logic [7:0] oen_ff, pull_ff, ien_ff, out_ff, in_ff, irq_en_ff;
	logic [3:0] bus_cfg_ff;
	logic bus_auto_ff, pin_auto_ff;
	logic [31:0] pin_cfg_ff;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oen_ff <= 8'h00;
			pull_ff <= 8'h00;
			ien_ff <= 8'h00;
			bus_cfg_ff <= 4'h0;
			bus_auto_ff <= RST_EVENT_FLAG_CLEAR[BUS_FLAG_AUTOCLR_BIT];
			pin_auto_ff <= RST_EVENT_FLAG_CLEAR[PIN_FLAG_AUTOCLR_BIT];
			pin_cfg_ff <= 32'h0000_0000;
			irq_en_ff <= 8'h00;
		end else begin
			if (wr_at(OFS_OUTPUT_DRIVE_EN, wr_go, waddr_ff)) oen_ff <= wdat_ff[7:0];
			if (wr_at(OFS_PULL_ENABLE, wr_go, waddr_ff)) pull_ff <= wdat_ff[7:0];
			if (wr_at(OFS_INPUT_PATH_EN, wr_go, waddr_ff)) ien_ff <= wdat_ff[7:0];
			if (wr_at(OFS_BUS_WAKE_CONFIG, wr_go, waddr_ff)) bus_cfg_ff <= wdat_ff[3:0];
			if (wr_at(OFS_EVENT_FLAG_CLEAR, wr_go, waddr_ff)) begin
				bus_auto_ff <= wdat_ff[BUS_FLAG_AUTOCLR_BIT];
				pin_auto_ff <= wdat_ff[PIN_FLAG_AUTOCLR_BIT];
			end
			if (wr_at(OFS_PIN_EVENT_CFG_LO, wr_go, waddr_ff)) pin_cfg_ff[15:0] <= wdat_ff;
			if (wr_at(OFS_PIN_EVENT_CFG_HI, wr_go, waddr_ff)) pin_cfg_ff[31:16] <= wdat_ff;
			if (wr_at(OFS_EVENT_IRQ_EN, wr_go, waddr_ff)) irq_en_ff <= wdat_ff[7:0];
		end
	end

	// ****************************
	// Output data and pins
	// ****************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_ff <= 8'h00;
		end else if (wr_go) begin
			case (waddr_ff)
				OFS_OUTPUT_VALUE: out_ff <= wdat_ff[7:0];
				OFS_OUTPUT_SET: out_ff <= out_ff | wdat_ff[7:0];
				OFS_OUTPUT_CLEAR: out_ff <= out_ff & ~wdat_ff[7:0];
				OFS_OUTPUT_TOGGLE: out_ff <= out_ff ^ wdat_ff[7:0];
				default: out_ff <= out_ff;
			endcase
		end
	end
	assign pin_out = out_ff;
	assign pin_oe_n = ~oen_ff;
	// Pin 2 has no pull-up fitted
	assign pull_en = pull_ff & ~(8'h01 << NOPULL_PIN);

	// ****************************
	// Pin synchronisers and input data
	// ****************************
	logic [7:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
	logic bus_s1_ff, bus_s2_ff, bus_s3_ff;
	// Third stage holds the previous level for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_ff <= 8'h00;
			pin_s2_ff <= 8'h00;
			pin_s3_ff <= 8'h00;
			bus_s1_ff <= 1'b0;
			bus_s2_ff <= 1'b0;
			bus_s3_ff <= 1'b0;
			in_ff <= 8'h00;
		end else begin
			pin_s1_ff <= pin_in;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			bus_s1_ff <= bus_activity;
			bus_s2_ff <= bus_s1_ff;
			bus_s3_ff <= bus_s2_ff;
			in_ff <= pin_s2_ff & ien_ff;
		end
	end
	// ****************************
	// Event flags and wake
	// ****************************
	logic [7:0] pin_det, pin_wake_en, pin_clr, pin_flag_ff;
	logic bus_det, bus_clr, bus_flag_ff;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_det[i] = trig(pin_cfg_ff[i*PIN_CFG_W +: 3], pin_s2_ff[i], pin_s3_ff[i]);
			pin_wake_en[i] = pin_cfg_ff[i*PIN_CFG_W + 3];
		end
	end
	assign bus_det = trig(bus_cfg_ff[2:0], bus_s2_ff, bus_s3_ff);
	assign bus_clr = wr_at(OFS_EVENT_FLAG_CLEAR, wr_go, waddr_ff) & wdat_ff[BUS_FLAG_CLR_BIT];
	assign pin_clr = wr_at(OFS_EVENT_FLAG_CLEAR, wr_go, waddr_ff) ? wdat_ff[7:0] : 8'h00;
	// A new detection wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_flag_ff <= 1'b0;
			pin_flag_ff <= 8'h00;
		end else begin
			bus_flag_ff <= bus_det | (bus_flag_ff & ~bus_clr & ~bus_auto_ff);
			pin_flag_ff <= pin_det | (pin_flag_ff & ~pin_clr & ~{8{pin_auto_ff}});
		end
	end
	assign wake_req = (bus_flag_ff & bus_cfg_ff[BUS_WAKE_EN_BIT]) | (|(pin_flag_ff & pin_wake_en));
	assign irq = |(pin_flag_ff & irq_en_ff);

	// ****************************
	// Read data
	// ****************************
	logic [15:0] rd_val;
	always_comb begin
		case (araddr & 12'hFFC)
			OFS_OUTPUT_DRIVE_EN: rd_val = {8'h00, oen_ff};
			OFS_PULL_ENABLE: rd_val = {8'h00, pull_en};
			OFS_INPUT_PATH_EN: rd_val = {8'h00, ien_ff};
			OFS_INPUT_LEVEL: rd_val = {8'h00, in_ff};
			OFS_OUTPUT_VALUE: rd_val = {8'h00, out_ff};
			OFS_BUS_WAKE_CONFIG: rd_val = {12'h000, bus_cfg_ff};
			// Flag clear bits self-clear, so they always read zero
			OFS_EVENT_FLAG_CLEAR: rd_val = {bus_auto_ff, pin_auto_ff, 14'h0000};
			OFS_PIN_EVENT_CFG_LO: rd_val = pin_cfg_ff[15:0];
			OFS_PIN_EVENT_CFG_HI: rd_val = pin_cfg_ff[31:16];
			OFS_EVENT_STATUS: rd_val = {7'h00, bus_flag_ff, pin_flag_ff};
			OFS_EVENT_IRQ_EN: rd_val = {8'h00, irq_en_ff};
			default: rd_val = 16'h0000;
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {16'h0000, rd_val};
			rresp_ff <= known(araddr & 12'hFFC) ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	// ****************************
	// Assertions
	// ****************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic set_wr;
	assign set_wr = wr_at(OFS_OUTPUT_SET, wr_go, waddr_ff);
	property p_bus_wake;
		bus_flag_ff && bus_cfg_ff[3] |-> wake_req;
	endproperty
	a_bus_wake: assert property (p_bus_wake) else $error("bus wake missing");
	property p_no_wake;
		!bus_cfg_ff[3] && pin_flag_ff == 8'h00 |-> !wake_req;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake without source");
	property p_rise;
		bus_cfg_ff[2:0] == 3'h0 && bus_s2_ff && !bus_s3_ff |=> bus_flag_ff;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");
	property p_alias_high;
		bus_cfg_ff[2:0] == 3'h7 && bus_s2_ff |=> bus_flag_ff;
	endproperty
	a_alias_high: assert property (p_alias_high) else $error("mode 7 not high level");
	property p_bus_auto;
		bus_auto_ff && bus_flag_ff && !bus_det |=> !bus_flag_ff;
	endproperty
	a_bus_auto: assert property (p_bus_auto) else $error("bus autoclear failed");
	property p_pin_auto;
		pin_auto_ff && pin_flag_ff[5] && !pin_det[5] |=> !pin_flag_ff[5];
	endproperty
	a_pin_auto: assert property (p_pin_auto) else $error("pin autoclear failed");
	property p_bus_clr;
		bus_clr && !bus_det |=> !bus_flag_ff;
	endproperty
	a_bus_clr: assert property (p_bus_clr) else $error("bus flag not cleared");
	property p_pin_clr;
		pin_clr[0] && !pin_det[0] |=> !pin_flag_ff[0];
	endproperty
	a_pin_clr: assert property (p_pin_clr) else $error("pin flag not cleared");
	property p_no_pull2;
		!pull_en[NOPULL_PIN];
	endproperty
	a_no_pull2: assert property (p_no_pull2) else $error("pin 2 pull driven");
	property p_set;
		set_wr |=> out_ff == ($past(out_ff) | $past(wdat_ff[7:0]));
	endproperty
	a_set: assert property (p_set) else $error("set write wrong");
	property p_oe;
		wr_at(OFS_OUTPUT_DRIVE_EN, wr_go, waddr_ff) |=> pin_oe_n == ~$past(wdat_ff[7:0]);
	endproperty
	a_oe: assert property (p_oe) else $error("pin drive mismatch");
	property p_resp;
		wr_go |=> bvalid;
	endproperty
	a_resp: assert property (p_resp) else $error("write response late");
	c_bus_flag: cover property (bus_flag_ff && wake_req);
	c_set: cover property (set_wr);
	c_irq: cover property (irq);
endmodule

// ===== logic/gpio_wake_pkg.sv
// Register map and field layout of the GPIO port with wake logic
package gpio_wake_pkg;
	// ****************************
	// Register byte addresses
	// ****************************
	localparam logic [11:0] OFS_OUTPUT_DRIVE_EN = 12'h004;
	localparam logic [11:0] OFS_PULL_ENABLE = 12'h008;
	localparam logic [11:0] OFS_INPUT_PATH_EN = 12'h00C;
	localparam logic [11:0] OFS_INPUT_LEVEL = 12'h010;
	localparam logic [11:0] OFS_OUTPUT_VALUE = 12'h014;
	localparam logic [11:0] OFS_OUTPUT_SET = 12'h018;
	localparam logic [11:0] OFS_OUTPUT_CLEAR = 12'h01C;
	localparam logic [11:0] OFS_OUTPUT_TOGGLE = 12'h020;
	localparam logic [11:0] OFS_BUS_WAKE_CONFIG = 12'hA28;
	localparam logic [11:0] OFS_EVENT_FLAG_CLEAR = 12'hA30;
	localparam logic [11:0] OFS_PIN_EVENT_CFG_LO = 12'hA40;
	localparam logic [11:0] OFS_PIN_EVENT_CFG_HI = 12'hA44;
	localparam logic [11:0] OFS_EVENT_STATUS = 12'hA50;
	localparam logic [11:0] OFS_EVENT_IRQ_EN = 12'hA54;
	// ****************************
	// Fields and reset values
	// ****************************
	localparam int BUS_WAKE_EN_BIT = 3;
	localparam int BUS_FLAG_AUTOCLR_BIT = 15;
	localparam int PIN_FLAG_AUTOCLR_BIT = 14;
	localparam int BUS_FLAG_CLR_BIT = 8;
	localparam int NOPULL_PIN = 2;
	localparam int PIN_CFG_W = 4;
	localparam logic [15:0] RST_EVENT_FLAG_CLEAR = 16'hC000;
	localparam logic [2:0] MODE_RISE = 3'h0;
	localparam logic [2:0] MODE_FALL = 3'h1;
	localparam logic [2:0] MODE_BOTH = 3'h2;
	localparam logic [2:0] MODE_HIGH = 3'h3;
	localparam logic [2:0] MODE_LOW = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== dv/gpio_pin_partner.sv
// Pin-side model: external drivers and pull-ups on the eight port pins
`timescale 1ns/1ps
module gpio_pin_partner (
	// Clock
	input wire logic clk,
	// Design side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pull_en,
	output logic [7:0] pin_in,
	// Bench side
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_oe,
	output logic [7:0] pin_wire
);
	logic [7:0] float_ff;
	// Undriven pins wander so a stale level is never trusted
	always_ff @(posedge clk) begin
		float_ff <= (float_ff === 8'hAA) ? 8'h55 : 8'hAA;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) begin
				pin_wire[i] = pin_out[i];
			end else if (ext_oe[i]) begin
				pin_wire[i] = ext_val[i];
			end else if (pull_en[i]) begin
				pin_wire[i] = 1'b1;
			end else begin
				pin_wire[i] = float_ff[i];
			end
		end
	end
	assign pin_in = pin_wire;
endmodule

// ===== dv/gpio_port_with_wake_clear_tb_top.sv
// Self-checking bench for the GPIO port with wake logic
`timescale 1ns/1ps
module gpio_port_with_wake_clear_tb_top;
	import gpio_wake_pkg::*;
	logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, bus_activity;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic [7:0] ext_val, ext_oe, v, m;
	logic [2:0] md, eff;
	logic idle;
	wire logic awready, wready, bvalid, arready, rvalid, wake_req, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] pin_in, pin_out, pin_oe_n, pull_en, pin_wire;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int cnt;
	gpio_wake_port #(.PINS(8)) uut (.clk, .resetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp, .pin_in, .pin_out, .pin_oe_n, .pull_en,
		.bus_activity, .wake_req, .irq);
	gpio_pin_partner pins (.clk, .pin_out, .pin_oe_n, .pull_en, .pin_in, .ext_val,
		.ext_oe, .pin_wire);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ****************************
	// Checking and bus tasks
	// ****************************
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic logic [33:0] ok(input logic [15:0] d);
		return {18'h00000, d};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Extra edge first, so strobes are never lowered and raised in one step
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		@(posedge clk);
		bq.push_back(r);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		@(posedge clk);
		rq.push_back(e);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (bvalid === 1'b1 && bready) begin
			check(34'(bresp), 34'(bq.pop_front()));
		end
		if (rvalid === 1'b1 && rready) begin
			check({rresp, rdata}, rq.pop_front());
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// ****************************
	// Test sequence
	// ****************************
	initial begin
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, bus_activity} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		ext_val = 8'h00;
		ext_oe = 8'hFF;
		void'($urandom(50));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(OFS_EVENT_FLAG_CLEAR, ok(RST_EVENT_FLAG_CLEAR));
		rd(OFS_OUTPUT_SET, ok(16'h0000));
		rd(12'h000, {RESP_SLVERR, 32'h0});
		wr(12'h000, 16'hFFFF, RESP_SLVERR);
		wr(OFS_BUS_WAKE_CONFIG, 16'hFFFF, RESP_OKAY);
		rd(OFS_BUS_WAKE_CONFIG, ok(16'h000F));
		$display("test reset_map done");
		v = 8'($urandom);
		m = 8'($urandom);
		wr(OFS_OUTPUT_DRIVE_EN, 16'h00FF, RESP_OKAY);
		wr(OFS_OUTPUT_VALUE, {8'h00, v}, RESP_OKAY);
		wr(OFS_OUTPUT_SET, {8'h00, m}, RESP_OKAY);
		v = v | m;
		rd(OFS_OUTPUT_VALUE, ok({8'h00, v}));
		m = 8'($urandom);
		wr(OFS_OUTPUT_CLEAR, {8'h00, m}, RESP_OKAY);
		v = v & ~m;
		rd(OFS_OUTPUT_VALUE, ok({8'h00, v}));
		m = 8'($urandom);
		wr(OFS_OUTPUT_TOGGLE, {8'h00, m}, RESP_OKAY);
		v = v ^ m;
		rd(OFS_OUTPUT_VALUE, ok({8'h00, v}));
		cyc(2);
		check(34'(pin_wire), 34'(v));
		wr(OFS_OUTPUT_DRIVE_EN, 16'h0000, RESP_OKAY);
		cyc(2);
		check(34'(pin_oe_n), 34'(8'hFF));
		$display("test outputs done");
		ext_oe <= 8'h00;
		wr(OFS_PULL_ENABLE, 16'h00FF, RESP_OKAY);
		cyc(2);
		check(34'(pull_en), 34'(8'hFB));
		v = 8'($urandom);
		ext_val <= v;
		ext_oe <= 8'hFF;
		wr(OFS_PULL_ENABLE, 16'h0000, RESP_OKAY);
		wr(OFS_INPUT_PATH_EN, 16'h00FF, RESP_OKAY);
		cyc(4);
		rd(OFS_INPUT_LEVEL, ok({8'h00, v}));
		m = 8'($urandom);
		wr(OFS_INPUT_PATH_EN, {8'h00, m}, RESP_OKAY);
		rd(OFS_INPUT_LEVEL, ok({8'h00, v & m}));
		$display("test inputs done");
		wr(OFS_EVENT_FLAG_CLEAR, 16'h0000, RESP_OKAY);
		// Last pass keeps mode zero with wake disabled
		for (int i = 0; i < 9; i++) begin
			md = (i == 8) ? 3'h0 : 3'(i);
			eff = (md > 3'h4) ? md - 3'h4 : md;
			idle = (eff == 3'h1 || eff == 3'h4);
			bus_activity <= idle;
			wr(OFS_BUS_WAKE_CONFIG, {12'h000, i < 8, md}, RESP_OKAY);
			cyc(6);
			wr(OFS_EVENT_FLAG_CLEAR, 16'h0100, RESP_OKAY);
			cyc(2);
			check(34'(wake_req), 34'(1'b0));
			bus_activity <= ~idle;
			cyc(6);
			check(34'(wake_req), 34'(i < 8));
		end
		wr(OFS_EVENT_FLAG_CLEAR, 16'hC100, RESP_OKAY);
		rd(OFS_EVENT_FLAG_CLEAR, ok(RST_EVENT_FLAG_CLEAR));
		wr(OFS_BUS_WAKE_CONFIG, 16'h0008, RESP_OKAY);
		bus_activity <= 1'b0;
		cyc(6);
		cnt = 0;
		bus_activity <= 1'b1;
		repeat (10) begin
			@(posedge clk);
			cnt += int'(wake_req === 1'b1);
		end
		check(34'(cnt), 34'h1);
		$display("test bus_wake done");
		ext_val <= 8'h00;
		wr(OFS_PIN_EVENT_CFG_LO, 16'h8888, RESP_OKAY);
		wr(OFS_PIN_EVENT_CFG_HI, 16'h8888, RESP_OKAY);
		wr(OFS_EVENT_FLAG_CLEAR, 16'h00FF, RESP_OKAY);
		wr(OFS_EVENT_IRQ_EN, 16'h00FF, RESP_OKAY);
		check(34'({irq, wake_req}), 34'(2'h0));
		ext_val <= 8'hFF;
		cyc(6);
		rd(OFS_EVENT_STATUS, ok(16'h00FF));
		check(34'({irq, wake_req}), 34'(2'h3));
		wr(OFS_EVENT_IRQ_EN, 16'h0000, RESP_OKAY);
		cyc(2);
		check(34'(irq), 34'(1'b0));
		wr(OFS_EVENT_IRQ_EN, 16'h00FF, RESP_OKAY);
		v = 8'hFF;
		for (int n = 0; n < 8; n++) begin
			wr(OFS_EVENT_FLAG_CLEAR, 16'(1 << n), RESP_OKAY);
			v[n] = 1'b0;
			rd(OFS_EVENT_STATUS, ok({8'h00, v}));
		end
		rd(OFS_EVENT_FLAG_CLEAR, ok(16'h0000));
		check(34'({irq, wake_req}), 34'(2'h0));
		$display("test pin_events done");
		stop_test();
	end
endmodule
